// ---- dv/cdop_ctrl_model.sv ----
// external controller model: full handshake reader of the fast parallel port
module cdop_ctrl_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        run_i,
  input  wire logic [1:0]  delay_i,
  input  wire logic        strobe_i,
  input  wire logic [15:0] data_i,
  output logic             req_o,
  output logic             got_o,
  output logic      [15:0] got_data_o
);
  logic [1:0] cnt_reg;  // idle cycles before the next request
  logic       busy_reg; // piece taken, waiting for ack to drop
  // request, take data at the edge the ack is seen, then wait for ack low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_o      <= 1'b0;
      got_o      <= 1'b0;
      got_data_o <= 16'h0000;
      cnt_reg    <= 2'h0;
      busy_reg   <= 1'b0;
    end else begin
      got_o <= 1'b0;
      if (req_o) begin
        // request held until ack, never dropped early
        if (strobe_i) begin
          req_o      <= 1'b0;
          got_o      <= 1'b1;
          got_data_o <= data_i;
          busy_reg   <= 1'b1;
        end
      end else if (busy_reg) begin
        if (!strobe_i) busy_reg <= 1'b0;
      end else if (run_i) begin
        // halting only stops new requests, a started one completes
        if (cnt_reg == delay_i) begin
          req_o   <= 1'b1;
          cnt_reg <= 2'h0;
        end else begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
    end
  end
endmodule

// ---- dv/tb.sv ----
// self-checking testbench of the continuous dump output port
`include "cdop_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, arst_n = 1'b0, dump = 1'b0, byte_fmt = 1'b0, sync_mode = 1'b0;
  logic        rear_sw2 = 1'b0, brd_sw2 = 1'b0, brd_sw3 = 1'b0, armed = 1'b0, done = 1'b0;
  logic        reacq_n = 1'b1, retx_n = 1'b1, ext_acq_n = 1'b1, run = 1'b0, strobe_q = 1'b0;
  logic [1:0]  port_state = 2'h0, dly = 2'h0;
  logic [16:0] valid_words = 17'h00001, mem_addr;
  logic [15:0] mem_data = 16'h0000, port_data, got_data, exp_w;
  logic [15:0] mem [64];    // stored samples, only low address bits modelled
  logic        req, got, acq_start, strobe, enable, flag, toggle, hold_next, sync_act, t0;
  int          seed = 8490, n_mismatch = 0, compares = 0, n_got = 0, exp_idx = 0, half = 0;
  int          cyc = 0, last_rise = -1000, i, k, src;
  cdop_top dut (.CLOCK_I(clk), .ARST_N_I(arst_n), .PORT_STATE_I(port_state), .DUMP_CONT_I(dump),
    .BYTE_FORMAT_I(byte_fmt), .SYNC_MODE_I(sync_mode), .REAR_SW2_CLOSED_I(rear_sw2),
    .BOARD_SW2_CLOSED_I(brd_sw2), .BOARD_SW3_CLOSED_I(brd_sw3), .REACQUIRE_REQUEST_N_I(reacq_n),
    .RETRANSMIT_REQUEST_N_I(retx_n), .EXTERNAL_ACQUIRE_INPUT_N_I(ext_acq_n), .HANDSHAKE_REQ_I(req),
    .VALID_WORDS_I(valid_words), .MEM_DATA_I(mem_data), .ACQ_ARMED_I(armed), .ACQ_DONE_I(done),
    .MEM_ADDR_O(mem_addr), .ACQ_START_O(acq_start), .PORT_DATA_O(port_data), .PORT_STROBE_O(strobe),
    .PORT_ENABLE_O(enable), .DATA_AVAILABLE_FLAG_O(flag), .TRANSFER_TOGGLE_O(toggle),
    .HOLD_NEXT_STATE_O(hold_next), .SYNC_ACTIVE_O(sync_act));
  cdop_ctrl_model ctrl (.clk_i(clk), .arst_n_i(arst_n), .run_i(run), .delay_i(dly), .strobe_i(strobe),
    .data_i(port_data), .req_o(req), .got_o(got), .got_data_o(got_data));
  // 125 MHz clock
  always #4 clk = ~clk;
  // one-cycle synchronous memory
  always @(posedge clk) mem_data <= mem[mem_addr[5:0]];
  // compare and count, never stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // stop the controller and let a started handshake finish
  task automatic halt();
    run <= 1'b0;
    step(200);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bench model: every piece is compared with the stored word it stands for
  always @(posedge clk) begin
    cyc++;
    // a request left standing from handshake mode is answered by a sync strobe: not a transfer
    if (got && !sync_act) begin
      exp_w = mem[exp_idx[5:0]];
      dly <= 2'($random(seed));
      if (byte_fmt) begin
        check(got_data, (half != 0) ? {8'h00, exp_w[7:0]} : {8'h00, exp_w[15:8]});
        if (half != 0) exp_idx++;
        half = 1 - half;
      end else begin
        check(got_data, exp_w);
        exp_idx++;
      end
      n_got++;
    end
    if (strobe && !strobe_q) begin
      check(cyc - last_rise >= 63, 1);
      last_rise = cyc;
      // synchronous mode: the receiver captures at the strobe edge
      if (sync_act) begin
        check(port_data, mem[exp_idx[5:0]]);
        exp_idx++;
        n_got++;
      end
    end
    strobe_q = strobe;
  end
  // watchdog: far beyond the few thousand cycles the sequence needs
  initial begin
    #240000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    for (k = 0; k < 64; k++) mem[k] = 16'($random(seed));
    step(16);
    arst_n <= 1'b1;
    step(10);
    check(enable, 1'b0);
    // one pass of valid data, word format then byte format
    for (k = 0; k < 2; k++) begin
      n_got = 0; exp_idx = 0; half = 0;
      byte_fmt <= k[0]; valid_words <= 17'h00005; port_state <= `CDOP_STATE_VALID; run <= 1'b1;
      for (i = 0; i < 4000 && n_got < 5 * (k + 1); i++) @(posedge clk);
      step(400);
      check(n_got, 5 * (k + 1));
      check(enable, 1'b1);
      port_state <= `CDOP_STATE_OFF; run <= 1'b0;
      step(20);
    end
    // synchronous mode, no handshake from the controller
    n_got = 0; exp_idx = 0;
    byte_fmt <= 1'b0; sync_mode <= 1'b1; valid_words <= 17'h00004; port_state <= `CDOP_STATE_VALID;
    for (i = 0; i < 2000 && n_got < 4; i++) @(posedge clk);
    step(300);
    check(n_got, 4);
    check(sync_act, 1'b1);
    port_state <= `CDOP_STATE_OFF; sync_mode <= 1'b0;
    step(20);
    // continuous dump, glitch then retransmit
    n_got = 0; exp_idx = 0; dump <= 1'b1; run <= 1'b1;
    for (i = 0; i < 2000 && n_got < 4; i++) @(posedge clk);
    check(enable, 1'b1);
    halt();
    t0 = toggle;
    retx_n <= 1'b0; step(1); retx_n <= 1'b1; step(10);
    check(toggle, t0);
    retx_n <= 1'b0;
    for (i = 0; i < 20 && toggle === t0; i++) @(posedge clk);
    check(toggle, !t0);
    retx_n <= 1'b1; exp_idx = 0; n_got = 0; run <= 1'b1;
    for (i = 0; i < 2000 && n_got < 3; i++) @(posedge clk);
    check(n_got, 3);
    // reacquire from the port pin, then from the rear input
    for (src = 0; src < 2; src++) begin
      halt();
      if (src == 0) reacq_n <= 1'b0;
      else ext_acq_n <= 1'b0;
      for (i = 0; i < 20 && acq_start !== 1'b1; i++) @(posedge clk);
      check(acq_start, 1'b1);
      t0 = toggle;
      retx_n <= 1'b0; step(10); retx_n <= 1'b1; step(5);
      check(toggle, t0);
      armed <= 1'b1;
      for (i = 0; i < 20 && flag !== 1'b1; i++) @(posedge clk);
      check(flag, 1'b1);
      check(hold_next, 1'b1);
      reacq_n <= 1'b1; ext_acq_n <= 1'b1;
      for (k = 0; k < 64; k++) mem[k] = 16'($random(seed));
      exp_idx = 0; n_got = 0; t0 = toggle;
      step(5); done <= 1'b1; armed <= 1'b0; step(1); done <= 1'b0; step(3);
      check(flag, 1'b0);
      check(toggle, !t0);
      run <= 1'b1;
      for (i = 0; i < 2000 && n_got < 3; i++) @(posedge clk);
      check(n_got, 3);
    end
    // switch-selected dump at power-up
    dump <= 1'b0; run <= 1'b0; sync_mode <= 1'b1; rear_sw2 <= 1'b1; brd_sw2 <= 1'b1; brd_sw3 <= 1'b0;
    arst_n <= 1'b0; step(16); arst_n <= 1'b1;
    for (i = 0; i < 20 && acq_start !== 1'b1; i++) @(posedge clk);
    check(acq_start, 1'b1);
    armed <= 1'b1; step(5);
    check(hold_next, 1'b1);
    check(sync_act, 1'b0);
    check(enable, 1'b1);
    complete_run();
  end
endmodule

// ---- logic/cdop_buf.sv ----
// small fifo between memory fetch and the parallel port
`include "cdop_cfg.svh"
module cdop_buf #(
  parameter int W     = `CDOP_WORD_W,
  parameter int DEPTH = `CDOP_BUF_DEPTH
) (
  input wire logic    clk_i,
  input wire logic    arst_n_i,
  cdop_buf_if.buffer  bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem_reg [DEPTH];   // storage words
  logic [PW-1:0] wptr_reg;         // write index
  logic [PW-1:0] rptr_reg;         // read index
  logic [PW:0]   count_reg;        // words held
  wire do_push = bus.in_valid & bus.in_ready;
  wire do_pop  = bus.out_valid & bus.out_ready;
  // full test at the count's own width: a pointer-wide cast of the depth would wrap to zero
  assign bus.in_ready  = (count_reg != (PW+1)'(DEPTH)) & ~bus.flush;
  assign bus.out_valid = (count_reg != '0) & ~bus.flush;
  assign bus.out_data  = mem_reg[rptr_reg];
  // wrap a pointer at the depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction
  // storage has no reset; count guards reads
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wptr_reg] <= bus.in_data;
    end
  end
  // pointers and fill level; flush wins over push and pop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else if (bus.flush) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (do_push) wptr_reg <= bump(wptr_reg);
      if (do_pop) rptr_reg <= bump(rptr_reg);
      count_reg <= count_reg + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
  a_no_overflow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    count_reg <= (PW+1)'(DEPTH)) else $error("buffer over depth");
endmodule

// ---- logic/cdop_buf_if.sv ----
// carrier between the fetch side, the two-entry buffer and the port side
interface cdop_buf_if #(parameter int W = 16);
  logic         in_valid;  // word offered by fetch
  logic         in_ready;  // buffer has room
  logic [W-1:0] in_data;   // fetched word
  logic         out_valid; // word waiting for the port
  logic         out_ready; // port takes the word
  logic [W-1:0] out_data;  // oldest word
  logic         flush;     // drop all held words
  modport buffer (input in_valid, in_data, out_ready, flush, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, flush, input in_ready, out_valid, out_data);
endinterface

// ---- logic/cdop_cfg.svh ----
// constants of the continuous dump output port
`ifndef CDOP_CFG_SVH
`define CDOP_CFG_SVH
`define CDOP_WORD_W      16
`define CDOP_BYTE_W      8
`define CDOP_ADDR_W      17
`define CDOP_MEM_BYTES   262144
`define CDOP_MEM_WORDS   (`CDOP_MEM_BYTES / 2)
`define CDOP_CLK_MHZ     125
`define CDOP_MIN_XFER_NS 500
`define CDOP_XFER_CYC    ((`CDOP_MIN_XFER_NS * `CDOP_CLK_MHZ + 999) / 1000)
`define CDOP_STROBE_CYC  (`CDOP_XFER_CYC / 2)
`define CDOP_PACE_W      7
`define CDOP_STATE_OFF   2'h0
`define CDOP_STATE_ALL   2'h1
`define CDOP_STATE_VALID 2'h2
`define CDOP_PIN_W       7
`define CDOP_PIN_IDLE    7'h3F
`define CDOP_STRAP_DONE  2'h3
`define CDOP_BUF_DEPTH   2
`endif

// ---- logic/cdop_pkg.sv ----
// types of the continuous dump output port
package cdop_pkg;
  typedef enum logic [1:0] {
    CDOP_IDLE = 2'h0,
    CDOP_SEND = 2'h1,
    CDOP_ARM  = 2'h2,
    CDOP_ACQ  = 2'h3
  } cdop_seq_t;
  typedef enum logic [1:0] {
    CDOP_O_LOAD = 2'h0,
    CDOP_O_SHOW = 2'h1,
    CDOP_O_DONE = 2'h2
  } cdop_out_t;
endpackage

// ---- logic/cdop_top.sv ----
// continuous dump output port: streams stored waveform words over the fast parallel port
// Operation
// - unsigned 16-bit words, at most 2 MHz
// - byte format sends high byte first
// - port enabled by state, dump or switches
// - dump resends until deactivated or reacquired
// - dump loops over whole linear array
// - rear sw2, board sw2 closed, sw3 open
// - switch dump powers up hold-next, handshake
// - reacquire request acquires then resumes sending
// - retransmit request restarts from data start
// - external acquire input acts like reacquire
// - available flag high while data readable (here also high while armed, and low from completion until data is read)
// - toggle flips at each new transmission
// - acquisition done drops flag, flips toggle
// - retransmit ignored while acquisition runs
// - word uses 16 lines, byte low eight
// - synchronous mode presents word with strobe edge
// - state all sends full memory, valid sends valid
`include "cdop_cfg.svh"
module cdop_top (
  input  wire logic                      CLOCK_I,
  input  wire logic                      ARST_N_I,
  input  wire logic [1:0]                PORT_STATE_I,
  input  wire logic                      DUMP_CONT_I,
  input  wire logic                      BYTE_FORMAT_I,
  input  wire logic                      SYNC_MODE_I,
  input  wire logic                      REAR_SW2_CLOSED_I,
  input  wire logic                      BOARD_SW2_CLOSED_I,
  input  wire logic                      BOARD_SW3_CLOSED_I,
  input  wire logic                      REACQUIRE_REQUEST_N_I,
  input  wire logic                      RETRANSMIT_REQUEST_N_I,
  input  wire logic                      EXTERNAL_ACQUIRE_INPUT_N_I,
  input  wire logic                      HANDSHAKE_REQ_I,
  input  wire logic [`CDOP_ADDR_W-1:0]   VALID_WORDS_I,
  input  wire logic [`CDOP_WORD_W-1:0]   MEM_DATA_I,
  input  wire logic                      ACQ_ARMED_I,
  input  wire logic                      ACQ_DONE_I,
  output logic      [`CDOP_ADDR_W-1:0]   MEM_ADDR_O,
  output logic                           ACQ_START_O,
  output logic      [`CDOP_WORD_W-1:0]   PORT_DATA_O,
  output logic                           PORT_STROBE_O,
  output logic                           PORT_ENABLE_O,
  output logic                           DATA_AVAILABLE_FLAG_O,
  output logic                           TRANSFER_TOGGLE_O,
  output logic                           HOLD_NEXT_STATE_O,
  output logic                           SYNC_ACTIVE_O
);
  localparam logic [`CDOP_PACE_W-1:0] XFER_CYC   = `CDOP_PACE_W'(`CDOP_XFER_CYC);
  localparam logic [`CDOP_PACE_W-1:0] STROBE_CYC = `CDOP_PACE_W'(`CDOP_STROBE_CYC);
  localparam logic [`CDOP_ADDR_W-1:0] FULL_LAST  = `CDOP_ADDR_W'(`CDOP_MEM_WORDS - 1);
  // pin synchroniser: first stage is read only by the second
  logic [`CDOP_PIN_W-1:0] pin_s1_reg, pin_s2_reg, pin_prev_reg;
  logic [1:0]             strap_cnt_reg;     // cycles until switches settle
  logic                   sw_dump_reg;       // dump selected by switches
  cdop_pkg::cdop_seq_t    seq_reg, seq_next;
  cdop_pkg::cdop_out_t    out_reg;
  logic [`CDOP_ADDR_W-1:0] addr_reg;         // next word to fetch
  logic                   rd_pend_reg;       // memory answer due this cycle
  logic                   done_reg;          // one-shot pass finished
  logic                   post_acq_reg;      // flag kept low after new acquisition
  logic [`CDOP_WORD_W-1:0] held_reg;         // word being sent
  logic                   phase_reg;         // low byte still to send
  logic [`CDOP_PACE_W-1:0] pace_reg;         // cycles until next presentation
  logic [`CDOP_PACE_W-1:0] wid_reg;          // strobe width in sync mode
  logic                   reacq_lvl_reg, retx_lvl_reg;
  cdop_buf_if #(.W(`CDOP_WORD_W)) bif ();
  cdop_buf #(.W(`CDOP_WORD_W), .DEPTH(`CDOP_BUF_DEPTH)) u_buf (
    .clk_i   (CLOCK_I),
    .arst_n_i(ARST_N_I),
    .bus     (bif.buffer)
  );
  // decoded pins
  wire [`CDOP_PIN_W-1:0] pin_raw = {HANDSHAKE_REQ_I, EXTERNAL_ACQUIRE_INPUT_N_I, RETRANSMIT_REQUEST_N_I,
                                    REACQUIRE_REQUEST_N_I, BOARD_SW3_CLOSED_I, BOARD_SW2_CLOSED_I,
                                    REAR_SW2_CLOSED_I};
  wire req_s      = pin_s2_reg[6];
  // two consecutive low samples count as a request, a single one is a glitch
  wire reacq_low  = (~pin_s2_reg[3] & ~pin_prev_reg[3]) | (~pin_s2_reg[5] & ~pin_prev_reg[5]);
  wire retx_low   = ~pin_s2_reg[4] & ~pin_prev_reg[4];
  wire reacq_ev   = reacq_low & ~reacq_lvl_reg;
  wire retx_ev    = retx_low & ~retx_lvl_reg;
  wire strap_now  = (strap_cnt_reg == `CDOP_STRAP_DONE - 2'h1);
  wire sw_dump_d  = pin_s2_reg[0] & pin_s2_reg[1] & ~pin_s2_reg[2];
  wire dump_on    = DUMP_CONT_I | sw_dump_reg;
  wire port_en    = (PORT_STATE_I != `CDOP_STATE_OFF) | dump_on;
  wire sync_md    = SYNC_MODE_I & ~dump_on;
  wire use_valid  = (PORT_STATE_I == `CDOP_STATE_VALID) & ~dump_on;
  wire [`CDOP_ADDR_W-1:0] last_addr = use_valid ? VALID_WORDS_I - `CDOP_ADDR_W'(1) : FULL_LAST;
  wire go_send    = (seq_reg == cdop_pkg::CDOP_IDLE) & (strap_cnt_reg == `CDOP_STRAP_DONE) & port_en & ~done_reg;
  wire go_reacq   = (seq_reg == cdop_pkg::CDOP_SEND) & dump_on & reacq_ev;
  wire go_retx    = (seq_reg == cdop_pkg::CDOP_SEND) & dump_on & retx_ev & ~reacq_ev;
  wire acq_end    = (seq_reg == cdop_pkg::CDOP_ACQ) & ACQ_DONE_I;
  wire new_tx     = go_send | go_retx | acq_end;
  wire stop_send  = (seq_reg == cdop_pkg::CDOP_SEND) & ~port_en;
  wire restart    = new_tx | go_reacq | stop_send | (seq_reg == cdop_pkg::CDOP_ARM);
  wire at_last    = rd_pend_reg & (addr_reg == last_addr);
  wire [`CDOP_ADDR_W-1:0] addr_step = at_last ? '0 : addr_reg + `CDOP_ADDR_W'(1);
  wire rd_issue   = (seq_reg == cdop_pkg::CDOP_SEND) & ~rd_pend_reg & bif.in_ready & ~restart;
  wire show_ok    = (out_reg == cdop_pkg::CDOP_O_LOAD) & (pace_reg == '0) & ~restart;
  wire show_lo    = show_ok & phase_reg;
  wire show_new   = show_ok & ~phase_reg & bif.out_valid;
  wire [`CDOP_WORD_W-1:0] word_new = bif.out_data;
  // byte format: high byte first, each byte on the low eight lines
  wire [`CDOP_WORD_W-1:0] hi_byte  = {{`CDOP_BYTE_W{1'b0}}, word_new[`CDOP_WORD_W-1:`CDOP_BYTE_W]};
  wire [`CDOP_WORD_W-1:0] lo_byte  = {{`CDOP_BYTE_W{1'b0}}, held_reg[`CDOP_BYTE_W-1:0]};
  assign bif.in_valid  = rd_pend_reg;
  assign bif.in_data   = MEM_DATA_I;
  assign bif.out_ready = show_new;
  assign bif.flush     = restart;
  // synchroniser and strap capture; active-low request lines idle high, handshake request idles low
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_s1_reg    <= `CDOP_PIN_IDLE;
      pin_s2_reg    <= `CDOP_PIN_IDLE;
      pin_prev_reg  <= `CDOP_PIN_IDLE;
      strap_cnt_reg <= '0;
      sw_dump_reg   <= 1'b0;
      reacq_lvl_reg <= 1'b0;
      retx_lvl_reg  <= 1'b0;
    end else begin
      pin_s1_reg    <= pin_raw;
      pin_s2_reg    <= pin_s1_reg;
      pin_prev_reg  <= pin_s2_reg;
      reacq_lvl_reg <= reacq_low;
      retx_lvl_reg  <= retx_low;
      if (strap_cnt_reg != `CDOP_STRAP_DONE) strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_now) sw_dump_reg <= sw_dump_d;   // caught once after release
    end
  end
  // sequencer next state
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      cdop_pkg::CDOP_IDLE: begin
        if (strap_now & sw_dump_d) seq_next = cdop_pkg::CDOP_ARM;     // hold-next at power up
        else if (go_send) seq_next = cdop_pkg::CDOP_SEND;
      end
      cdop_pkg::CDOP_SEND: begin
        if (stop_send) seq_next = cdop_pkg::CDOP_IDLE;
        else if (go_reacq) seq_next = cdop_pkg::CDOP_ARM;
        else if (at_last & ~dump_on) seq_next = cdop_pkg::CDOP_IDLE;
      end
      cdop_pkg::CDOP_ARM: begin
        if (ACQ_ARMED_I) seq_next = cdop_pkg::CDOP_ACQ;
      end
      cdop_pkg::CDOP_ACQ: begin
        if (ACQ_DONE_I) seq_next = cdop_pkg::CDOP_SEND;
      end
      default: seq_next = cdop_pkg::CDOP_IDLE;
    endcase
  end
  // sequencer, fetch address and status pins
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      seq_reg               <= cdop_pkg::CDOP_IDLE;
      addr_reg              <= '0;
      MEM_ADDR_O            <= '0;
      rd_pend_reg           <= 1'b0;
      done_reg              <= 1'b0;
      post_acq_reg          <= 1'b0;
      ACQ_START_O           <= 1'b0;
      TRANSFER_TOGGLE_O     <= 1'b0;
      DATA_AVAILABLE_FLAG_O <= 1'b0;
      HOLD_NEXT_STATE_O     <= 1'b0;
      PORT_ENABLE_O         <= 1'b0;
      SYNC_ACTIVE_O         <= 1'b0;
    end else begin
      seq_reg           <= seq_next;
      PORT_ENABLE_O     <= port_en;
      SYNC_ACTIVE_O     <= sync_md;
      ACQ_START_O       <= (seq_next == cdop_pkg::CDOP_ARM) & (seq_reg != cdop_pkg::CDOP_ARM);
      HOLD_NEXT_STATE_O <= (seq_next == cdop_pkg::CDOP_ACQ);
      if (new_tx) TRANSFER_TOGGLE_O <= ~TRANSFER_TOGGLE_O;
      if (~port_en) done_reg <= 1'b0;
      else if (at_last & ~dump_on) done_reg <= 1'b1;
      if (restart) begin
        addr_reg    <= '0;
        MEM_ADDR_O  <= '0;
        rd_pend_reg <= 1'b0;
      end else begin
        rd_pend_reg <= rd_issue;
        if (rd_pend_reg) begin
          addr_reg   <= addr_step;
          MEM_ADDR_O <= addr_step;   // mirror, so the memory sees the address at the issuing edge
        end
      end
      // flag: up when armed, down on completion, up again once data is read
      if (acq_end) post_acq_reg <= 1'b1;
      else if (req_s | sync_md) post_acq_reg <= 1'b0;
      if ((seq_reg == cdop_pkg::CDOP_ACQ) & ~ACQ_DONE_I) DATA_AVAILABLE_FLAG_O <= 1'b1;
      else if (acq_end | (seq_next == cdop_pkg::CDOP_IDLE) | (seq_next == cdop_pkg::CDOP_ARM))
        DATA_AVAILABLE_FLAG_O <= 1'b0;
      else if ((show_new | show_lo) & ~post_acq_reg) DATA_AVAILABLE_FLAG_O <= 1'b1;
    end
  end
  // port side: pacing, handshake or self-made strobe
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      out_reg       <= cdop_pkg::CDOP_O_LOAD;
      held_reg      <= '0;
      phase_reg     <= 1'b0;
      pace_reg      <= '0;
      wid_reg       <= '0;
      PORT_DATA_O   <= '0;
      PORT_STROBE_O <= 1'b0;
    end else if (restart) begin
      out_reg       <= cdop_pkg::CDOP_O_LOAD;
      phase_reg     <= 1'b0;
      PORT_STROBE_O <= 1'b0;
    end else begin
      if (pace_reg != '0) pace_reg <= pace_reg - `CDOP_PACE_W'(1);
      case (out_reg)
        cdop_pkg::CDOP_O_LOAD: begin
          if (show_new | show_lo) begin
            pace_reg <= XFER_CYC - `CDOP_PACE_W'(1);
            out_reg  <= cdop_pkg::CDOP_O_SHOW;
          end
          if (show_new) begin
            held_reg    <= word_new;
            phase_reg   <= BYTE_FORMAT_I;
            PORT_DATA_O <= BYTE_FORMAT_I ? hi_byte : word_new;
          end else if (show_lo) begin
            phase_reg   <= 1'b0;
            PORT_DATA_O <= lo_byte;
          end
        end
        cdop_pkg::CDOP_O_SHOW: begin
          if (sync_md | req_s) begin
            PORT_STROBE_O <= 1'b1;
            pace_reg      <= XFER_CYC - `CDOP_PACE_W'(1);  // a late request must not squeeze strobes
            wid_reg       <= STROBE_CYC;
            out_reg       <= cdop_pkg::CDOP_O_DONE;
          end
        end
        cdop_pkg::CDOP_O_DONE: begin
          if (wid_reg != '0) wid_reg <= wid_reg - `CDOP_PACE_W'(1);
          if (sync_md ? (wid_reg == '0) : ~req_s) begin
            PORT_STROBE_O <= 1'b0;
            out_reg       <= cdop_pkg::CDOP_O_LOAD;
          end
        end
        default: out_reg <= cdop_pkg::CDOP_O_LOAD;
      endcase
    end
  end
  // checks
  int unsigned gap_cnt_reg;   // cycles since last presentation
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) gap_cnt_reg <= `CDOP_XFER_CYC;
    else gap_cnt_reg <= (show_new | show_lo) ? 0 : gap_cnt_reg + 1;
  end
  a_rate_limit: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (show_new | show_lo) |-> gap_cnt_reg >= `CDOP_XFER_CYC - 1) else $error("words too close");
  a_byte_order: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    show_new & BYTE_FORMAT_I |=> PORT_DATA_O == {8'h00, held_reg[15:8]} && phase_reg) else $error("high byte not first");
  a_port_gate: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (seq_reg == cdop_pkg::CDOP_SEND) & ~port_en |=> seq_reg == cdop_pkg::CDOP_IDLE) else $error("send while disabled");
  a_reacq_arms: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    go_reacq |=> seq_reg == cdop_pkg::CDOP_ARM && ACQ_START_O ##1 !ACQ_START_O) else $error("reacquire not armed");
  a_retx_addr: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    go_retx |=> addr_reg == '0 && TRANSFER_TOGGLE_O != $past(TRANSFER_TOGGLE_O)) else $error("retransmit not restarted");
  a_done_flag: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    acq_end |=> !DATA_AVAILABLE_FLAG_O && $changed(TRANSFER_TOGGLE_O)) else $error("completion not signalled");
  a_retx_ignored: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    (seq_reg == cdop_pkg::CDOP_ACQ) & ~ACQ_DONE_I |=> $stable(TRANSFER_TOGGLE_O)) else $error("toggle during acquisition");
  a_glitch_reject: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    reacq_ev |-> (!pin_s2_reg[3] && $past(pin_s2_reg[3]) == 1'b0) || (!pin_s2_reg[5] && $past(pin_s2_reg[5]) == 1'b0))
    else $error("glitch accepted");
  a_sync_strobe: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
    $rose(PORT_STROBE_O) & sync_md & ~restart |=> PORT_STROBE_O [*8]) else $error("strobe too short");
  c_dump_loop: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I) at_last & dump_on);
  c_reacquire: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I) acq_end);
  c_retransmit: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I) go_retx);
  c_byte_low: cover property (@(posedge CLOCK_I) disable iff (!ARST_N_I) show_lo);
endmodule
